// ---- hdl/tap_pkg.sv ----
// Constants and types shared by the test access port files.
package tap_pkg;

    localparam int IR_WIDTH = 6;
    localparam int ID_WIDTH = 32;

    localparam logic [IR_WIDTH-1:0] OP_EXTEST   = 6'h00;
    localparam logic [IR_WIDTH-1:0] OP_SAMPLE   = 6'h01;
    localparam logic [IR_WIDTH-1:0] OP_IDENT    = 6'h02;
    localparam logic [IR_WIDTH-1:0] OP_HIGHZ    = 6'h03;
    localparam logic [IR_WIDTH-1:0] OP_AC_TRAIN = 6'h3C;
    localparam logic [IR_WIDTH-1:0] OP_AC_PULSE = 6'h3D;
    localparam logic [IR_WIDTH-1:0] OP_CLAMP    = 6'h3E;
    localparam logic [IR_WIDTH-1:0] OP_BYPASS   = 6'h3F;

    // Loaded into the instruction shift register in Capture-IR; low bits are 01.
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE_PATTERN = 6'h01;
    localparam logic                BYPASS_CAPTURE     = 1'h0;

    // Identification value layout.
    localparam int ID_RSVD_POS  = 0;
    localparam int MAKER_LSB    = 1;
    localparam int MAKER_WIDTH  = 11;
    localparam int PART_LSB     = 12;
    localparam int PART_WIDTH   = 16;
    localparam int REV_LSB      = 28;
    localparam int REV_WIDTH    = 4;
    localparam logic ID_RSVD_VALUE = 1'h1;

    localparam int SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        TLR       = 4'h0,
        RTI       = 4'h1,
        SEL_DR    = 4'h2,
        CAP_DR    = 4'h3,
        SHIFT_DR  = 4'h4,
        EXIT1_DR  = 4'h5,
        PAUSE_DR  = 4'h6,
        EXIT2_DR  = 4'h7,
        UPD_DR    = 4'h8,
        SEL_IR    = 4'h9,
        CAP_IR    = 4'hA,
        SHIFT_IR  = 4'hB,
        EXIT1_IR  = 4'hC,
        PAUSE_IR  = 4'hD,
        EXIT2_IR  = 4'hE,
        UPD_IR    = 4'hF
    } tap_state_t;

    typedef enum logic [1:0] {
        SEL_IDENT  = 2'h0,
        SEL_BYPASS = 2'h1,
        SEL_BSR    = 2'h2
    } dr_sel_t;

endpackage : tap_pkg

// ---- hdl/tap_pins_if.sv ----
// Synchronised test port pins and test clock edge strobes.
`timescale 1ns/10ps
interface tap_pins_if;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic trst_n;

    modport sync_side (output tck_rise, output tck_fall, output tms, output tdi, output trst_n);
    modport core_side (input tck_rise, input tck_fall, input tms, input tdi, input trst_n);
endinterface : tap_pins_if

// ---- hdl/tap_pin_sync.sv ----
// Two-stage synchronisers for the test port pins and test clock edge finder.
`timescale 1ns/10ps
module tap_pin_sync
    import tap_pkg::*;
(
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    // Raw pins
    input  wire logic  tck,
    input  wire logic  tms,
    input  wire logic  tdi,
    input  wire logic  trst_n,
    // Synchronised side
    tap_pins_if.sync_side pins
);

    logic [SYNC_STAGES-1:0] tck_sync;
    logic [SYNC_STAGES-1:0] tms_sync;
    logic [SYNC_STAGES-1:0] tdi_sync;
    logic [SYNC_STAGES-1:0] trst_n_sync;
    logic                   tck_last;

    // Test reset syncs to low so the port starts quiet.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            tck_sync    <= '0;
            tms_sync    <= '1;
            tdi_sync    <= '1;
            trst_n_sync <= '0;
            tck_last    <= 1'h0;
        end
        else
        begin
            tck_sync    <= {tck_sync[0], tck};
            tms_sync    <= {tms_sync[0], tms};
            tdi_sync    <= {tdi_sync[0], tdi};
            trst_n_sync <= {trst_n_sync[0], trst_n};
            tck_last    <= tck_sync[SYNC_STAGES-1];
        end
    end

    assign pins.tck_rise = tck_sync[SYNC_STAGES-1] & ~tck_last;
    assign pins.tck_fall = ~tck_sync[SYNC_STAGES-1] & tck_last;
    assign pins.tms      = tms_sync[SYNC_STAGES-1];
    assign pins.tdi      = tdi_sync[SYNC_STAGES-1];
    assign pins.trst_n   = trst_n_sync[SYNC_STAGES-1];

endmodule : tap_pin_sync

// ---- hdl/tap_ident_ac.sv ----
// Test access port with identification, bypass and AC test instructions.
`timescale 1ns/10ps

// Function
// R1: Any port reset makes identification current.
// R2: Identification value bit zero is one.
// R3: Tester reads first bit to detect identification.
// R4: Single-bit bypass register also exists.
// R5: Identification shifts out 32 bits, LSB first.
// R6: Fields: reserved, maker, part, revision.
// R7: Capture-IR loads pattern ending binary 01.
// R8: AC instructions take effect at Update-IR fall.
// R9: AC scan data shifts TDI to TDO.
// R10: Train pulses last while in Run-Test/Idle.
// R11: Pulse width equals Run-Test/Idle dwell.
// R12: No Run-Test/Idle means plain DC behaviour.
// R13: Tester never loads reserved opcodes.
// R14: Idle system holds port in reset.
// R15: Tester drives test clock low when unused.
// R16: Six-bit instruction; train and pulse opcodes.
// R17: Capture-DR loads zero into bypass.
// R18: Unassigned opcodes reserved; identification is 000010.
module tap_ident_ac
    import tap_pkg::*;
#(
    parameter int                       AC_WIDTH   = 4,
    parameter logic [MAKER_WIDTH-1:0]   MAKER_CODE = 11'h0A5, // Arbitrary value.
    parameter logic [PART_WIDTH-1:0]    PART_CODE  = 16'h1234, // Arbitrary value.
    parameter logic [REV_WIDTH-1:0]     REVISION   = 4'h1
)
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    // Test port pins
    input  wire logic                tck,
    input  wire logic                tms,
    input  wire logic                tdi,
    input  wire logic                trst_n,
    output logic                     tdo,
    output logic                     tdo_oe,
    // AC tested outputs
    output logic [AC_WIDTH-1:0]      ac_out,
    output logic                     ac_drive
);

    localparam logic [ID_WIDTH-1:0] ID_VALUE =
        {REVISION, PART_CODE, MAKER_CODE, ID_RSVD_VALUE}; // R6

    tap_pins_if pins ();

    tap_pin_sync u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .tck     (tck),
        .tms     (tms),
        .tdi     (tdi),
        .trst_n  (trst_n),
        .pins    (pins)
    );

    tap_state_t             state;
    tap_state_t             next_state;
    logic [IR_WIDTH-1:0]    ir;
    logic [IR_WIDTH-1:0]    ir_sr;
    logic [ID_WIDTH-1:0]    id_sr;
    logic                   byp;
    logic [AC_WIDTH-1:0]    bsr;
    logic [AC_WIDTH-1:0]    bsr_upd;
    logic                   phase;
    logic                   dr_bit;
    logic [AC_WIDTH-1:0]    next_ac;
    logic                   port_reset;
    dr_sel_t                sel;

    // Reserved opcodes are routed to bypass so a stray load stays harmless.
    function automatic dr_sel_t dr_select(input logic [IR_WIDTH-1:0] op);
        if (op == OP_IDENT)
            return SEL_IDENT;
        else if (op == OP_EXTEST || op == OP_SAMPLE || op == OP_AC_TRAIN || op == OP_AC_PULSE)
            return SEL_BSR; // R9 R16
        else
            return SEL_BYPASS; // R18
    endfunction : dr_select

    function automatic logic drives_pins(input logic [IR_WIDTH-1:0] op);
        return (op == OP_EXTEST || op == OP_AC_TRAIN || op == OP_AC_PULSE || op == OP_CLAMP);
    endfunction : drives_pins

    assign sel        = dr_select(ir);
    assign port_reset = sys_rst | ~pins.trst_n;

    always_comb
    begin
        next_state = state;
        case (state)
            TLR:      next_state = pins.tms ? TLR      : RTI;
            RTI:      next_state = pins.tms ? SEL_DR   : RTI;
            SEL_DR:   next_state = pins.tms ? SEL_IR   : CAP_DR;
            CAP_DR:   next_state = pins.tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_state = pins.tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_state = pins.tms ? UPD_DR   : PAUSE_DR;
            PAUSE_DR: next_state = pins.tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_state = pins.tms ? UPD_DR   : SHIFT_DR;
            UPD_DR:   next_state = pins.tms ? SEL_DR   : RTI;
            SEL_IR:   next_state = pins.tms ? TLR      : CAP_IR;
            CAP_IR:   next_state = pins.tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_state = pins.tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_state = pins.tms ? UPD_IR   : PAUSE_IR;
            PAUSE_IR: next_state = pins.tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_state = pins.tms ? UPD_IR   : SHIFT_IR;
            UPD_IR:   next_state = pins.tms ? SEL_DR   : RTI;
            default:  next_state = TLR;
        endcase
    end

    // Five rising test clocks with mode select high always land in TLR.
    always_ff @(posedge mclk)
    begin
        if (port_reset)
            state <= TLR;
        else if (pins.tck_rise)
            state <= next_state;
    end

    // Instruction register loads on the falling test clock in Update-IR; port reset and TLR force identification.
    always_ff @(posedge mclk)
    begin
        if (port_reset || state == TLR)
            ir <= OP_IDENT; // R1
        else if (pins.tck_fall && state == UPD_IR)
            ir <= ir_sr; // R8
    end

    always_ff @(posedge mclk)
    begin
        if (port_reset)
            ir_sr <= IR_CAPTURE_PATTERN;
        else if (pins.tck_rise && state == CAP_IR)
            ir_sr <= IR_CAPTURE_PATTERN; // R7
        else if (pins.tck_rise && state == SHIFT_IR)
            ir_sr <= {pins.tdi, ir_sr[IR_WIDTH-1:1]};
    end

    always_ff @(posedge mclk)
    begin
        if (port_reset)
            id_sr <= ID_VALUE;
        else if (pins.tck_rise && state == CAP_DR && sel == SEL_IDENT)
            id_sr <= ID_VALUE; // R2 R5
        else if (pins.tck_rise && state == SHIFT_DR && sel == SEL_IDENT)
            id_sr <= {pins.tdi, id_sr[ID_WIDTH-1:1]}; // R5
    end

    always_ff @(posedge mclk)
    begin
        if (port_reset)
            byp <= BYPASS_CAPTURE;
        else if (pins.tck_rise && state == CAP_DR && sel == SEL_BYPASS)
            byp <= BYPASS_CAPTURE; // R4 R17
        else if (pins.tck_rise && state == SHIFT_DR && sel == SEL_BYPASS)
            byp <= pins.tdi; // R4
    end

    // The boundary cells stand in for the AC tested pins only.
    always_ff @(posedge mclk)
    begin
        if (port_reset)
            bsr <= '0;
        else if (pins.tck_rise && state == CAP_DR && sel == SEL_BSR)
            bsr <= ac_out;
        else if (pins.tck_rise && state == SHIFT_DR && sel == SEL_BSR)
            bsr <= {pins.tdi, bsr[AC_WIDTH-1:1]}; // R9
    end

    always_ff @(posedge mclk)
    begin
        if (port_reset)
            bsr_upd <= '0;
        else if (pins.tck_fall && state == UPD_DR && sel == SEL_BSR)
            bsr_upd <= bsr;
    end

    always_comb
    begin
        case (sel)
            SEL_IDENT: dr_bit = id_sr[0];
            SEL_BSR:   dr_bit = bsr[0];
            default:   dr_bit = byp;
        endcase
    end

    // Data leaves on the falling edge so the tester samples a stable bit.
    always_ff @(posedge mclk)
    begin
        if (port_reset)
        begin
            tdo    <= 1'h0;
            tdo_oe <= 1'h0;
        end
        else if (pins.tck_fall)
        begin
            tdo    <= (state == SHIFT_IR) ? ir_sr[0] : dr_bit; // R5 R9
            tdo_oe <= (state == SHIFT_IR) || (state == SHIFT_DR);
        end
    end

    // Train phase flips on every rising test clock spent in Run-Test/Idle.
    always_ff @(posedge mclk)
    begin
        if (port_reset || state != RTI || ir != OP_AC_TRAIN)
            phase <= 1'h0;
        else if (pins.tck_rise)
            phase <= ~phase; // R10
    end

    always_comb
    begin
        if (state == RTI && ir == OP_AC_TRAIN)
            next_ac = bsr_upd ^ {AC_WIDTH{phase}}; // R10
        else if (state == RTI && ir == OP_AC_PULSE)
            next_ac = ~bsr_upd; // R11
        else
            next_ac = bsr_upd; // R12
    end

    always_ff @(posedge mclk)
    begin
        if (port_reset)
        begin
            ac_out   <= '0;
            ac_drive <= 1'h0;
        end
        else
        begin
            ac_out   <= next_ac;
            ac_drive <= drives_pins(ir);
        end
    end

    sequence ir_loaded_s;
        pins.tck_fall && state == UPD_IR;
    endsequence

    sequence train_dwell_s;
        (state == RTI && ir == OP_AC_TRAIN) ##1 (state == RTI && ir == OP_AC_TRAIN);
    endsequence

    sequence pulse_dwell_s;
        (state == RTI && ir == OP_AC_PULSE) ##1 (state == RTI && ir == OP_AC_PULSE);
    endsequence

    sequence dc_hold_s;
        (state != RTI && drives_pins(ir)) ##1 (state != RTI && drives_pins(ir));
    endsequence

    reset_ident_a: assert property (@(posedge mclk) disable iff (sys_rst) // R1
        (state == TLR) |=> (ir == OP_IDENT))
        else $error("Identification not current after port reset.");

    id_capture_a: assert property (@(posedge mclk) disable iff (sys_rst) // R2
        (pins.tck_rise && state == CAP_DR && sel == SEL_IDENT && pins.trst_n)
        |=> (id_sr == ID_VALUE && id_sr[ID_RSVD_POS] == 1'h1))
        else $error("Identification capture wrong.");

    id_first_bit_a: assert property (@(posedge mclk) disable iff (sys_rst) // R5
        (pins.tck_fall && state == SHIFT_DR && sel == SEL_IDENT && pins.trst_n)
        |=> (tdo == $past(dr_bit) && tdo_oe))
        else $error("Identification bit not presented on data out.");

    ir_capture_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
        (pins.tck_rise && state == CAP_IR && pins.trst_n) |=> (ir_sr[1:0] == 2'h1))
        else $error("Instruction capture pattern wrong.");

    ir_update_a: assert property (@(posedge mclk) disable iff (sys_rst) // R8
        (ir_loaded_s and (pins.trst_n)) |=> (ir == $past(ir_sr)))
        else $error("Instruction not taken at Update-IR fall.");

    bypass_zero_a: assert property (@(posedge mclk) disable iff (sys_rst) // R17
        (pins.tck_rise && state == CAP_DR && sel == SEL_BYPASS && pins.trst_n)
        |=> (byp == 1'h0))
        else $error("Bypass capture not zero.");

    bsr_shift_a: assert property (@(posedge mclk) disable iff (sys_rst) // R9
        (pins.tck_rise && state == SHIFT_DR && sel == SEL_BSR && pins.trst_n)
        |=> (bsr[AC_WIDTH-1] == $past(pins.tdi)))
        else $error("Scan data not shifted in.");

    train_out_a: assert property (@(posedge mclk) disable iff (sys_rst) // R10
        train_dwell_s |-> (ac_out == ($past(bsr_upd) ^ {AC_WIDTH{$past(phase)}})))
        else $error("Train output does not follow phase.");

    pulse_out_a: assert property (@(posedge mclk) disable iff (sys_rst) // R11
        pulse_dwell_s |-> (ac_out == ~$past(bsr_upd)))
        else $error("Pulse output not inverted during dwell.");

    dc_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // R12
        dc_hold_s |-> (ac_out == $past(bsr_upd)))
        else $error("Outputs differ from plain external test.");

endmodule : tap_ident_ac

// ---- verification/tap_tester.sv ----
// Board-level test controller model that drives the test port pins.
`timescale 1ns/10ps
module tap_tester
    import tap_pkg::*;
#(
    parameter int AC_WIDTH = 4
)
(
    // Pacing clock
    input  wire logic                mclk,
    // Test port pins
    output logic                     tck,
    output logic                     tms,
    output logic                     tdi,
    output logic                     trst_n,
    input  wire logic                tdo,
    // AC tested outputs
    input  wire logic [AC_WIDTH-1:0] ac_out
);
    // Pins rest at their pulled levels and the test clock is held low while unused.
    initial
    begin
        tck    = 1'h0;
        tms    = 1'h1;
        tdi    = 1'h1;
        trst_n = 1'h1;
    end

    // One test clock of 8 system clocks. Mode and data change as the test clock falls, so
    // they are long settled when the synchronised rising edge is seen; the outputs are
    // sampled late because the design sees each pin edge only some system clocks after.
    task automatic cycle(input logic m, input logic d, output logic q,
                         output logic [AC_WIDTH-1:0] a);
        @(negedge mclk);
        tck = 1'h0;
        tms = m;
        tdi = d;
        repeat (2) @(negedge mclk);
        a = ac_out;
        repeat (2) @(negedge mclk);
        tck = 1'h1;
        repeat (3) @(negedge mclk);
        q = tdo;
    endtask : cycle

    task automatic idle();
        @(negedge mclk);
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
    endtask : idle

    task automatic pulse_reset();
        idle();
        trst_n = 1'h0;
        repeat (8) @(negedge mclk);
        trst_n = 1'h1;
        repeat (8) @(negedge mclk);
    endtask : pulse_reset
endmodule : tap_tester

// ---- verification/test_tap_ident_ac.sv ----
// Self-checking bench for the identification and AC test instructions.
`timescale 1ns/10ps
module test_tap_ident_ac;
    import tap_pkg::*;
    localparam int                     W     = 4;
    localparam logic [MAKER_WIDTH-1:0] MAKER = 11'h2C9; // Arbitrary value.
    localparam logic [PART_WIDTH-1:0]  PART  = 16'h5A3E; // Arbitrary value.
    localparam logic [REV_WIDTH-1:0]   REV   = 4'h6; // Arbitrary value.
    localparam logic [31:0]            ID    = {REV, PART, MAKER, ID_RSVD_VALUE};

    logic          mclk;
    logic          sys_rst;
    logic          tck;
    logic          tms;
    logic          tdi;
    logic          trst_n;
    logic          tdo;
    logic          tdo_oe;
    logic [W-1:0]  ac_out;
    logic          ac_drive;
    logic          last_tdo;
    logic [W-1:0]  last_ac;
    int            err_count;
    int            n_compared;
    int            cyc;

    tap_ident_ac #(.AC_WIDTH(W), .MAKER_CODE(MAKER), .PART_CODE(PART), .REVISION(REV))
        tap_ident_ac_inst (.mclk(mclk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
                           .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .ac_out(ac_out),
                           .ac_drive(ac_drive));

    tap_tester #(.AC_WIDTH(W))
        tap_tester_inst (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
                         .tdo(tdo), .ac_out(ac_out));

    initial
    begin
        mclk = 1'h0;
        cyc  = 0;
    end

    always #25 mclk = ~mclk;

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 8000)
        begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic step(input logic m, input logic d);
        tap_tester_inst.cycle(m, d, last_tdo, last_ac);
    endtask : step

    // Walks from Run-Test/Idle or Update to a shift, moves n bits and ends in Update.
    task automatic scan(input logic ir, input int n, input logic [63:0] d,
                        output logic [63:0] o);
        o = '0;
        step(1'h1, 1'h1);
        if (ir)
            step(1'h1, 1'h1);
        step(1'h0, 1'h1);
        step(1'h0, 1'h1);
        for (int k = 0; k < n; k++)
        begin
            step(k == n - 1, d[k]);
            o[k] = last_tdo;
            if (k == 0)
                check(64'(tdo_oe), 64'h1, "data out enable on");
        end
        step(1'h1, 1'h1);
        check(64'(tdo_oe), 64'h0, "data out enable off");
    endtask : scan

    initial
    begin
        logic [63:0]         d;
        logic [63:0]         o;
        logic [W-1:0]        v;
        logic [W-1:0]        e;
        logic [IR_WIDTH-1:0] op;
        int                  n;
        int                  j;
        logic                exp_q[$];
        err_count  = 0;
        n_compared = 0;
        sys_rst    = 1'h1;
        void'($urandom(15460));
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'h0;
        repeat (4) @(negedge mclk);
        step(1'h0, 1'h1);
        for (int r = 0; r < 2; r++)
        begin
            scan(1'h1, IR_WIDTH, 64'((r == 0) ? OP_BYPASS : OP_CLAMP), o);
            check(64'(o[IR_WIDTH-1:0]), 64'(IR_CAPTURE_PATTERN), "ir capture");
            d = {$urandom, $urandom};
            scan(1'h0, 33, d, o);
            check(64'(o[0]), 64'(BYPASS_CAPTURE), "bypass capture");
            check(64'(o[32:1]), 64'(d[31:0]), "bypass pass");
            if (r == 0)
                tap_tester_inst.pulse_reset();
            else
                repeat (5) step(1'h1, 1'h1);
            step(1'h0, 1'h1);
            scan(1'h0, 64, d, o);
            check(64'(o[0]), 64'h1, "first id bit");
            check(64'(o[31:0]), 64'(ID), "id value");
            check(64'(o[63:32]), 64'(d[31:0]), "id pass");
            // Expected stream: the identification value first, then the bits fed in.
            exp_q = {};
            for (int b = 0; b < 64; b++)
                exp_q.push_back((b < 32) ? ID[b] : d[b - 32]);
            for (int b = 0; b < 64; b++)
                check(64'(o[b]), 64'(exp_q.pop_front()), "id stream bit");
            $display("test ident reset %0d done", r);
        end
        for (int t = 0; t < 3; t++)
        begin
            op = (t == 0) ? OP_AC_TRAIN : (t == 1) ? OP_AC_PULSE : OP_EXTEST;
            scan(1'h1, IR_WIDTH, 64'(op), o);
            d = 64'($urandom);
            scan(1'h0, 2 * W, d, o);
            check(64'(o[2*W-1:W]), 64'(d[W-1:0]), "ac scan pass");
            check(64'(ac_drive), 64'h1, "ac drive on");
            v = d[2*W-1:W];
            n = 2 + int'($urandom % 5);
            // Through Capture-DR and Update-DR with no shift first, then a random Run-Test/Idle dwell and out again.
            for (int k = 0; k < n + 6; k++)
            begin
                step(!(k == 1 || (k >= 4 && k < 4 + n)), 1'h1);
                j = k - 4;
                e = (j >= 1 && j <= n && t < 2) ? ((t == 1) ? ~v : v ^ {W{~j[0]}}) : v;
                if (k >= 1)
                    check(64'(last_ac), 64'(e), "ac outputs");
            end
            repeat (5) step(1'h1, 1'h1);
            check(64'(ac_drive), 64'h0, "ac drive off");
            step(1'h0, 1'h1);
            $display("test ac instruction %0d done", t);
        end
        tap_tester_inst.idle();
        tally_and_finish();
    end
endmodule : test_tap_ident_ac
